// File: bench/sar_axis_sva.sv
module sar_axis_sva (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic external_stop_input_n_i,
  input wire logic end_limit_input_n_i,
  input wire logic [7:0] data_o,
  input wire logic data_oe_n_o,
  input wire logic pulse_o,
  input wire logic busy_o
);
  // ----------------------------------------------------------------
  // Port checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  idle_bus_zero_a: assert property (
    data_oe_n_o |-> data_o == 8'h00) else $error("read data not zero while released");
  read_drive_a: assert property (
    (!rd_n_i && !cs_n_i) [*4] |=> !data_oe_n_o) else $error("read not answered");
  read_release_a: assert property (
    rd_n_i [*4] |=> data_oe_n_o) else $error("read data not released");
  oe_cause_a: assert property (
    $fell(data_oe_n_o) |-> !$past(rd_n_i, 2) && !$past(cs_n_i, 2))
    else $error("data driven without a read");
  stop_holds_a: assert property (
    (!external_stop_input_n_i) [*4] |=> !$rose(busy_o)) else $error("started under stop");
  limit_holds_a: assert property (
    (!end_limit_input_n_i) [*4] |=> !$rose(busy_o)) else $error("started under limit");
  // Reset is asynchronous, so this one is judged while reset is low
  reset_quiet_a: assert property (disable iff (1'b0)
    !rst_n_i |-> data_oe_n_o && !busy_o && !pulse_o && data_o == 8'h00)
    else $error("outputs active in reset");
  pulse_busy_a: assert property (
    pulse_o |-> busy_o || $past(busy_o)) else $error("pulse while stopped");
endmodule : sar_axis_sva

bind sar_axis sar_axis_sva chk (
  .clk_sys_i(clk_sys_i),
  .rst_n_i(rst_n_i),
  .cs_n_i(cs_n_i),
  .rd_n_i(rd_n_i),
  .external_stop_input_n_i(external_stop_input_n_i),
  .end_limit_input_n_i(end_limit_input_n_i),
  .data_o(data_o),
  .data_oe_n_o(data_oe_n_o),
  .pulse_o(pulse_o),
  .busy_o(busy_o)
);

// File: bench/sar_axis_test.sv
`include "sar_regs.svh"
module sar_axis_test;
  timeunit 1ns;
  timeprecision 1ps;
  import sar_pkg::*;
  logic clk_sys_i = 1'b0, rst_n_i = 1'b1, cs_n, rd_n, wr_n, oe_n, pulse, busy;
  logic start_n = 1'b1, stop_n = 1'b1, limit_n = 1'b1;
  logic [1:0] addr;
  logic [7:0] wdata, rdata;
  int fail_count = 0, check_count = 0, cyc = 0, pcnt = 0;

  always #2 clk_sys_i = ~clk_sys_i;

  sar_host host (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .cs_n_o(cs_n), .rd_n_o(rd_n),
    .wr_n_o(wr_n), .addr_o(addr), .wdata_o(wdata));
  sar_axis dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n), .rd_n_i(rd_n),
    .wr_n_i(wr_n), .addr_i(addr), .data_i(wdata), .external_start_input_n_i(start_n),
    .external_stop_input_n_i(stop_n), .end_limit_input_n_i(limit_n), .data_o(rdata),
    .data_oe_n_o(oe_n), .pulse_o(pulse), .busy_o(busy));

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rdc(input logic [1:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    chk(d, exp);
  endtask : rdc

  task automatic sel(input logic [2:0] r, input logic ext);
    host.wr(`SAR_ADDR_CMD, {`SAR_CMD_SEL, 2'b00, ext, r});
  endtask : sel

  // Pulses are counted on the falling edge, away from the edge that launches them
  always @(negedge clk_sys_i) begin
    cyc++;
    if (pulse === 1'b1) pcnt++;
    // Whole run needs about 1400 cycles; far beyond that means a hang
    if (cyc == 20000) begin
      fail_count++;
      $display("mismatch at %0t: run did not end", $time);
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    sel(`SAR_REG_START_SPD, 1'b1);
    rdc(`SAR_ADDR_LOW, 8'h01);
    for (int r = 1; r <= 5; r++) begin
      sel(r[2:0], 1'b1);
      host.wr(`SAR_ADDR_LOW, 8'h40 + r[7:0]);
      host.wr(`SAR_ADDR_MID, 8'h01);
      rdc(`SAR_ADDR_LOW, 8'h40 + r[7:0]);
      rdc(`SAR_ADDR_MID, 8'h01);
    end
    sel(`SAR_REG_IDLE, 1'b1);
    host.wr(`SAR_ADDR_LOW, 8'hff);
    rdc(`SAR_ADDR_LOW, 8'h07);
    sel(`SAR_REG_ENV, 1'b1);
    host.wr(`SAR_ADDR_LOW, 8'h01);
    sel(`SAR_REG_RDOWN, 1'b1);
    rdc(`SAR_ADDR_UPP, 8'h01);
    sel(`SAR_REG_RATE, 1'b1);
    rdc(`SAR_ADDR_UPP, 8'h8b);
    host.wr(`SAR_ADDR_CMD, 8'h60);
    sel(`SAR_REG_HIGH_SPD, 1'b1);
    rdc(`SAR_ADDR_UPP, 8'h60);
    host.wr(`SAR_ADDR_CMD, 8'h40);
    rdc(`SAR_ADDR_UPP, 8'h40);
  endtask : t_regs

  task automatic t_status;
    sel(`SAR_REG_ENV, 1'b1);
    rdc(`SAR_ADDR_UPP, `SAR_CHIP_ID);
    rdc(`SAR_ADDR_MID, 8'h00);
    sel(`SAR_REG_START_SPD, 1'b0);
    stop_n = 1'b0;
    rdc(`SAR_ADDR_LOW, 8'h01);
    rdc(`SAR_ADDR_MID, 8'h00);
    rdc(`SAR_ADDR_UPP, 8'h00);
    stop_n = 1'b1;
  endtask : t_status

  // Speeds of 0x1ffe keep the pulse period at two clocks
  task automatic t_preset;
    for (int r = 1; r <= 2; r++) begin
      sel(r[2:0], 1'b1);
      host.wr(`SAR_ADDR_LOW, 8'hfe);
      host.wr(`SAR_ADDR_MID, 8'h1f);
    end
    sel(`SAR_REG_PRESET, 1'b0);
    for (int a = 1; a <= 3; a++) host.wr(a[1:0], 8'hff);
    for (int a = 1; a <= 3; a++) rdc(a[1:0], 8'hff);
    host.wr(`SAR_ADDR_LOW, 8'h03);
    host.wr(`SAR_ADDR_MID, 8'h00);
    host.wr(`SAR_ADDR_UPP, 8'h00);
    pcnt = 0;
    host.wr(`SAR_ADDR_CMD, 8'h05);
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(negedge clk_sys_i);
    // The last pulse leaves together with busy, so let the counter see it
    repeat (2) @(negedge clk_sys_i);
    chk(pcnt[7:0], 8'd10);
    rdc(`SAR_ADDR_LOW, 8'h00);
    rdc(`SAR_ADDR_CMD, 8'h08);
  endtask : t_preset

  task automatic t_inhibit(input logic lim);
    sel(`SAR_REG_PRESET, 1'b0);
    host.wr(`SAR_ADDR_LOW, 8'h03);
    stop_n = lim;
    limit_n = !lim;
    repeat (6) @(negedge clk_sys_i);
    pcnt = 0;
    host.wr(`SAR_ADDR_CMD, 8'h07);
    start_n = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    start_n = 1'b1;
    repeat (20) @(negedge clk_sys_i);
    chk({7'h00, busy}, 8'h00);
    chk(pcnt[7:0], 8'd0);
    rdc(`SAR_ADDR_CMD, lim ? 8'h04 : 8'h02);
    stop_n = 1'b1;
    limit_n = 1'b1;
  endtask : t_inhibit

  // Ramp from speed 0x1ff8 toward 0x1ffe; step interval is the rate, doubled with S-curve.
  // Speed is sampled about 95 clocks after go, between step edges at 80 and 120, or at 80 and 160 with an 80-clock step interval.
  task automatic t_ramp(input logic [7:0] ctrl, input logic [7:0] rate, input logic [7:0] exp);
    logic [7:0] d;
    sel(`SAR_REG_START_SPD, 1'b1);
    host.wr(`SAR_ADDR_LOW, 8'hf8);
    sel(`SAR_REG_IDLE, 1'b1);
    host.wr(`SAR_ADDR_LOW, 8'h00);
    sel(`SAR_REG_RATE, 1'b1);
    host.wr(`SAR_ADDR_LOW, rate);
    host.wr(`SAR_ADDR_MID, 8'h00);
    host.wr(`SAR_ADDR_CMD, ctrl);
    sel(`SAR_REG_IDLE, 1'b1);
    host.wr(`SAR_ADDR_CMD, 8'h11);
    repeat (90) @(negedge clk_sys_i);
    rdc(`SAR_ADDR_MID, exp);
    rdc(`SAR_ADDR_CMD, 8'h01);
    sel(`SAR_REG_ENV, 1'b1);
    host.rd(`SAR_ADDR_MID, d);
    chk(d & 8'hfe, 8'h02);
    host.wr(`SAR_ADDR_CMD, 8'h08);
    chk({7'h00, busy}, 8'h00);
  endtask : t_ramp

  initial begin
    // A real falling edge so the asynchronous reset acts before the first clock
    #1 rst_n_i = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    t_regs();
    t_status();
    t_preset();
    t_inhibit(1'b0);
    t_inhibit(1'b1);
    t_ramp(8'h40, 8'h28, 8'hfa);
    t_ramp(8'h60, 8'h28, 8'hf9);
    t_ramp(8'h60, 8'h14, 8'hfa);
    finish_test();
  end
endmodule : sar_axis_test

// File: bench/sar_host.sv
module sar_host (
  input wire logic clk_sys_i,
  input wire logic [7:0] rdata_i,
  output logic cs_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic [1:0] addr_o,
  output logic [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Host bus cycles, driven on the falling edge
  // ----------------------------------------------------------------
  initial begin
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    addr_o = 2'h0;
    wdata_o = 8'h00;
  end

  // Three-clock strobe and four-clock gap keep the synchronisers happy
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    cs_n_o = 1'b0;
    wr_n_o = 1'b0;
    addr_o = a;
    wdata_o = d;
    repeat (3) @(negedge clk_sys_i);
    wr_n_o = 1'b1;
    cs_n_o = 1'b1;
    wdata_o = ~d;  // Released bus must not look like the last value
    repeat (4) @(negedge clk_sys_i);
  endtask : wr

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(negedge clk_sys_i);
    cs_n_o = 1'b0;
    rd_n_o = 1'b0;
    addr_o = a;
    // Take the data on a falling edge, well after the registered answer has settled
    repeat (4) @(negedge clk_sys_i);
    d = rdata_i;
    @(negedge clk_sys_i);
    rd_n_o = 1'b1;
    cs_n_o = 1'b1;
    repeat (4) @(negedge clk_sys_i);
  endtask : rd
endmodule : sar_host

// File: include/sar_pkg.sv
package sar_pkg;

  typedef enum logic [1:0] {
    SAR_IDLE,
    SAR_WAIT_START,
    SAR_RUN
  } sar_run_t;

  typedef struct packed {
    sar_run_t run_st;
    logic [23:0] remain;
    logic [12:0] start_spd;
    logic [12:0] high_spd;
    logic [9:0] rate;
    logic [9:0] mult;
    logic [15:0] rdown;
    logic [2:0] idle;
    logic env;
    logic [7:0] cmd_start;
    logic [7:0] cmd_ctrl;
    logic [7:0] cmd_sel;
    logic [7:0] cmd_out;
    logic [12:0] cur_spd;
    logic [13:0] pulse_tmr;
    logic [10:0] ramp_tmr;
    logic [2:0] idle_left;
    logic wr_act;
    logic [1:0] wr_addr;
    logic [7:0] wr_data;
    logic start_prev;
    logic stop_flag;
    logic limit_flag;
    logic done_flag;
    logic [7:0] dout;
    logic doe_n;
    logic pulse;
    logic busy;
  } sar_state_t;

endpackage : sar_pkg

// File: include/sar_regs.svh
`ifndef SAR_REGS_SVH
`define SAR_REGS_SVH

// ----------------------------------------------------------------
// Bus addresses (A1, A0)
// ----------------------------------------------------------------
`define SAR_ADDR_CMD 2'h0
`define SAR_ADDR_LOW 2'h1
`define SAR_ADDR_MID 2'h2
`define SAR_ADDR_UPP 2'h3

// ----------------------------------------------------------------
// Command type in bits 7:6 of a command byte
// ----------------------------------------------------------------
`define SAR_CMD_START 2'h0
`define SAR_CMD_CTRL 2'h1
`define SAR_CMD_SEL 2'h2
`define SAR_CMD_OUT 2'h3

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SAR_START_GO_BIT 0
`define SAR_START_INHIBIT_BIT 1
`define SAR_START_PRESET_BIT 2
`define SAR_START_STOP_BIT 3
`define SAR_START_RAMP_BIT 4
`define SAR_CTRL_SCURVE_BIT 5
`define SAR_SEL_EXT_BIT 3

// ----------------------------------------------------------------
// Register numbers
// ----------------------------------------------------------------
`define SAR_REG_PRESET 3'h0
`define SAR_REG_START_SPD 3'h1
`define SAR_REG_HIGH_SPD 3'h2
`define SAR_REG_RATE 3'h3
`define SAR_REG_MULT 3'h4
`define SAR_REG_RDOWN 3'h5
`define SAR_REG_IDLE 3'h6
`define SAR_REG_ENV 3'h7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SAR_RST_PRESET 24'h000000
`define SAR_RST_SPEED 13'h0001
`define SAR_RST_RATE 10'h002
`define SAR_RST_MULT 10'h002
`define SAR_RST_RDOWN 16'h0000
`define SAR_RST_IDLE 3'h0
`define SAR_RST_CMD 8'h00

// ----------------------------------------------------------------
// Timing and identity
// ----------------------------------------------------------------
`define SAR_PERIOD_BASE 14'h2000
// Identification value is arbitrary
`define SAR_CHIP_ID 8'h5a

`endif

// File: src/sar_axis.sv
`include "sar_regs.svh"

module sar_axis (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [1:0] addr_i,
  input wire logic [7:0] data_i,
  input wire logic external_start_input_n_i,
  input wire logic external_stop_input_n_i,
  input wire logic end_limit_input_n_i,
  output logic [7:0] data_o,
  output logic data_oe_n_o,
  output logic pulse_o,
  output logic busy_o
);
  import sar_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [15:0] pins_raw;
  logic [15:0] pins_sy;

  assign pins_raw = {cs_n_i, rd_n_i, wr_n_i, addr_i, data_i,
                     external_start_input_n_i, external_stop_input_n_i,
                     end_limit_input_n_i};

  sar_sync #(.W(16)) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .async_i(pins_raw),
    .sync_o(pins_sy)
  );

  logic cs_act;
  logic rd_act;
  logic wr_act;
  logic [1:0] addr_sy;
  logic [7:0] din_sy;
  logic start_act;
  logic stop_act;
  logic limit_act;

  assign cs_act = ~pins_sy[15];
  assign rd_act = ~pins_sy[14] & cs_act;
  assign wr_act = ~pins_sy[13] & cs_act;
  assign addr_sy = pins_sy[12:11];
  assign din_sy = pins_sy[10:3];
  assign start_act = ~pins_sy[2];
  assign stop_act = ~pins_sy[1];
  assign limit_act = ~pins_sy[0];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  sar_state_t s_r;
  sar_state_t s_nxt;

  logic [2:0] sel;
  logic ext_mon;
  logic scurve;
  logic preset_mode;
  logic [23:0] reg_view;
  logic [23:0] reg_new;
  logic [10:0] ramp_load;
  logic [13:0] period_load;
  logic [12:0] target_spd;
  logic [7:0] primary_status_word;
  logic [7:0] secondary_status_word;
  logic [7:0] output_terminal_status_word;
  logic [7:0] rd_mux;

  assign sel = s_r.cmd_sel[2:0];
  assign ext_mon = s_r.cmd_sel[`SAR_SEL_EXT_BIT];
  assign scurve = s_r.cmd_ctrl[`SAR_CTRL_SCURVE_BIT];
  assign preset_mode = s_r.cmd_start[`SAR_START_PRESET_BIT];
  // Doubling the step interval doubles the whole ramp time
  assign ramp_load = scurve ? {s_r.rate, 1'b0} : {1'b0, s_r.rate};
  assign period_load = `SAR_PERIOD_BASE - {1'b0, s_r.cur_spd};
  // Ramp down once the pulses left reach the ramp-down point
  assign target_spd = (preset_mode && s_r.remain <= {8'h00, s_r.rdown}) ?
                      s_r.start_spd : s_r.high_spd;

  assign primary_status_word = {4'h0, s_r.done_flag, s_r.limit_flag, s_r.stop_flag, s_r.busy};
  assign secondary_status_word = {5'h0, start_act, limit_act, stop_act};
  assign output_terminal_status_word = {6'h0, s_r.busy, s_r.pulse};

  // ----------------------------------------------------------------
  // Register view for byte writes and reads
  // ----------------------------------------------------------------
  always_comb begin
    case (sel)
      `SAR_REG_PRESET: reg_view = s_r.remain;
      `SAR_REG_START_SPD: reg_view = {11'h000, s_r.start_spd};
      `SAR_REG_HIGH_SPD: reg_view = {11'h000, s_r.high_spd};
      `SAR_REG_RATE: reg_view = {14'h0000, s_r.rate};
      `SAR_REG_MULT: reg_view = {14'h0000, s_r.mult};
      `SAR_REG_RDOWN: reg_view = {8'h00, s_r.rdown};
      `SAR_REG_IDLE: reg_view = {21'h000000, s_r.idle};
      default: reg_view = {23'h000000, s_r.env};
    endcase
  end

  always_comb begin
    reg_new = reg_view;
    case (s_r.wr_addr)
      `SAR_ADDR_LOW: reg_new[7:0] = s_r.wr_data;
      `SAR_ADDR_MID: reg_new[15:8] = s_r.wr_data;
      `SAR_ADDR_UPP: reg_new[23:16] = s_r.wr_data;
      default: reg_new = reg_view;
    endcase
  end

  // ----------------------------------------------------------------
  // Read monitor
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = primary_status_word;
    if (addr_sy != `SAR_ADDR_CMD) begin
      if (sel == `SAR_REG_PRESET) begin
        case (addr_sy)
          `SAR_ADDR_LOW: rd_mux = s_r.remain[7:0];
          `SAR_ADDR_MID: rd_mux = s_r.remain[15:8];
          default: rd_mux = s_r.remain[23:16];
        endcase
      end else if (!ext_mon) begin
        rd_mux = (addr_sy == `SAR_ADDR_LOW) ? secondary_status_word : 8'h00;
      end else begin
        case (sel)
          `SAR_REG_ENV: begin
            case (addr_sy)
              `SAR_ADDR_LOW: rd_mux = secondary_status_word;
              `SAR_ADDR_MID: rd_mux = output_terminal_status_word;
              default: rd_mux = `SAR_CHIP_ID;
            endcase
          end
          `SAR_REG_IDLE: begin
            case (addr_sy)
              `SAR_ADDR_LOW: rd_mux = {5'h00, s_r.idle};
              `SAR_ADDR_MID: rd_mux = s_r.cur_spd[7:0];
              default: rd_mux = {3'h0, s_r.cur_spd[12:8]};
            endcase
          end
          default: begin
            case (addr_sy)
              `SAR_ADDR_LOW: rd_mux = reg_view[7:0];
              `SAR_ADDR_MID: rd_mux = reg_view[15:8];
              default: begin
                case (sel)
                  `SAR_REG_START_SPD: rd_mux = s_r.cmd_start;
                  `SAR_REG_HIGH_SPD: rd_mux = s_r.cmd_ctrl;
                  `SAR_REG_RATE: rd_mux = s_r.cmd_sel;
                  `SAR_REG_MULT: rd_mux = s_r.cmd_out;
                  default: rd_mux = {7'h00, s_r.env};
                endcase
              end
            endcase
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.pulse = 1'b0;
    s_nxt.start_prev = start_act;
    s_nxt.doe_n = ~rd_act;
    s_nxt.dout = rd_act ? rd_mux : 8'h00;

    // Capture while the strobe is low, commit on its release
    s_nxt.wr_act = wr_act;
    if (wr_act) begin
      s_nxt.wr_addr = addr_sy;
      s_nxt.wr_data = din_sy;
    end

    // Motion sequencer
    case (s_r.run_st)
      SAR_IDLE: begin
        s_nxt.busy = 1'b0;
      end
      SAR_WAIT_START: begin
        s_nxt.busy = 1'b0;
        if (stop_act || limit_act) begin
          s_nxt.run_st = SAR_IDLE;
          s_nxt.stop_flag = stop_act;
          s_nxt.limit_flag = limit_act;
        end else if (start_act && !s_r.start_prev) begin
          s_nxt.run_st = SAR_RUN;
          s_nxt.busy = 1'b1;
        end
      end
      SAR_RUN: begin
        if (stop_act || limit_act) begin
          s_nxt.run_st = SAR_IDLE;
          s_nxt.busy = 1'b0;
          s_nxt.stop_flag = stop_act;
          s_nxt.limit_flag = limit_act;
        end else begin
          if (s_r.pulse_tmr <= 14'h0001) begin
            s_nxt.pulse = 1'b1;
            s_nxt.pulse_tmr = period_load;
            if (s_r.idle_left != 3'h0) begin
              s_nxt.idle_left = s_r.idle_left - 3'h1;
            end else if (preset_mode) begin
              s_nxt.remain = s_r.remain - 24'h000001;
              if (s_r.remain <= 24'h000001) begin
                s_nxt.run_st = SAR_IDLE;
                s_nxt.busy = 1'b0;
                s_nxt.done_flag = 1'b1;
              end
            end
          end else begin
            s_nxt.pulse_tmr = s_r.pulse_tmr - 14'h0001;
          end
          // With ramping on, idle pulses run at start speed, ramping begins after them
          if (s_r.idle_left == 3'h0 && s_r.cmd_start[`SAR_START_RAMP_BIT]) begin
            if (s_r.ramp_tmr <= 11'h001) begin
              s_nxt.ramp_tmr = ramp_load;
              if (s_r.cur_spd < target_spd) begin
                s_nxt.cur_spd = s_r.cur_spd + 13'h0001;
              end else if (s_r.cur_spd > target_spd) begin
                s_nxt.cur_spd = s_r.cur_spd - 13'h0001;
              end
            end else begin
              s_nxt.ramp_tmr = s_r.ramp_tmr - 11'h001;
            end
          end else if (!s_r.cmd_start[`SAR_START_RAMP_BIT]) begin
            s_nxt.cur_spd = s_r.high_spd;
          end
        end
      end
      default: begin
        s_nxt.run_st = SAR_IDLE;
        s_nxt.busy = 1'b0;
      end
    endcase

    // Write commit
    if (s_r.wr_act && !wr_act) begin
      if (s_r.wr_addr == `SAR_ADDR_CMD) begin
        case (s_r.wr_data[7:6])
          `SAR_CMD_START: begin
            s_nxt.cmd_start = s_r.wr_data;
            if (s_r.wr_data[`SAR_START_STOP_BIT]) begin
              s_nxt.run_st = SAR_IDLE;
              s_nxt.busy = 1'b0;
            end else if (s_r.wr_data[`SAR_START_GO_BIT] && s_r.run_st == SAR_IDLE) begin
              // No prior reset command is required
              s_nxt.stop_flag = 1'b0;
              s_nxt.limit_flag = 1'b0;
              s_nxt.done_flag = 1'b0;
              s_nxt.cur_spd = s_r.start_spd;
              s_nxt.idle_left = s_r.idle;
              s_nxt.pulse_tmr = `SAR_PERIOD_BASE - {1'b0, s_r.start_spd};
              s_nxt.ramp_tmr = ramp_load;
              if (stop_act || limit_act) begin
                s_nxt.stop_flag = stop_act;
                s_nxt.limit_flag = limit_act;
              end else if (s_r.wr_data[`SAR_START_INHIBIT_BIT]) begin
                s_nxt.run_st = SAR_WAIT_START;
              end else begin
                s_nxt.run_st = SAR_RUN;
                s_nxt.busy = 1'b1;
              end
            end
          end
          `SAR_CMD_CTRL: s_nxt.cmd_ctrl = s_r.wr_data;
          `SAR_CMD_SEL: s_nxt.cmd_sel = s_r.wr_data;
          default: s_nxt.cmd_out = s_r.wr_data;
        endcase
      end else begin
        case (sel)
          `SAR_REG_PRESET: s_nxt.remain = reg_new;
          `SAR_REG_START_SPD: s_nxt.start_spd = reg_new[12:0];
          `SAR_REG_HIGH_SPD: s_nxt.high_spd = reg_new[12:0];
          `SAR_REG_RATE: s_nxt.rate = reg_new[9:0];
          `SAR_REG_MULT: s_nxt.mult = reg_new[9:0];
          `SAR_REG_RDOWN: s_nxt.rdown = reg_new[15:0];
          `SAR_REG_IDLE: s_nxt.idle = reg_new[2:0];
          default: s_nxt.env = reg_new[0];
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
      s_r.run_st <= SAR_IDLE;
      s_r.remain <= `SAR_RST_PRESET;
      s_r.start_spd <= `SAR_RST_SPEED;
      s_r.high_spd <= `SAR_RST_SPEED;
      s_r.rate <= `SAR_RST_RATE;
      s_r.mult <= `SAR_RST_MULT;
      s_r.rdown <= `SAR_RST_RDOWN;
      s_r.idle <= `SAR_RST_IDLE;
      s_r.cmd_start <= `SAR_RST_CMD;
      s_r.cmd_ctrl <= `SAR_RST_CMD;
      s_r.cmd_sel <= `SAR_RST_CMD;
      s_r.cmd_out <= `SAR_RST_CMD;
      s_r.doe_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign data_o = s_r.dout;
  assign data_oe_n_o = s_r.doe_n;
  assign pulse_o = s_r.pulse;
  assign busy_o = s_r.busy;

endmodule : sar_axis

// File: src/sar_sync.sv
module sar_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sar_sync_t;

  sar_sync_t s_r;
  sar_sync_t s_nxt;

  // Inputs idle high, so reset to ones avoids a false strobe at release
  always_comb begin
    s_nxt = s_r;
    s_nxt.meta = async_i;
    s_nxt.stable = s_r.meta;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= '1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sync_o = s_r.stable;

endmodule : sar_sync
